// ---- rtl/gain_offset_pkg.sv ----
/*
  Shared constants for the per-stream gain and offset correction block:
  register indices and byte addresses, field layouts, reset values, codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses of ADDR_W bits.
*/
package gain_offset_pkg;

  localparam int SAMPLE_W  = 14;
  localparam int OFFSET_W  = 10;
  localparam int GAIN_W    = 5;
  localparam int REG_W     = 16;
  localparam int NUM_CORR  = 5;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = 4;
  localparam int MULT_W    = 15;
  localparam int GAIN_FRAC = 12;

  // register indices; the byte address is four times the index
  localparam logic [ADDR_W-3:0] IDX_ENABLES     = 6'h03;
  localparam logic [ADDR_W-3:0] IDX_CONV2_EVEN  = 6'h10;
  localparam logic [ADDR_W-3:0] IDX_CONV3_ODD   = 6'h11;
  localparam logic [ADDR_W-3:0] IDX_CONV3_EVEN  = 6'h12;
  localparam logic [ADDR_W-3:0] IDX_CONV4_ODD   = 6'h13;
  localparam logic [ADDR_W-3:0] IDX_CONV4_EVEN  = 6'h14;
  localparam logic [ADDR_W-3:0] IDX_STATUS      = 6'h20;

  localparam logic [ADDR_W-1:0] ADDR_ENABLES    = {IDX_ENABLES, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = {IDX_STATUS, 2'h0};
  // entry 0 is conv2 even, entry 4 is conv4 even
  localparam logic [NUM_CORR-1:0][ADDR_W-1:0] CORR_ADDR = {
    {IDX_CONV4_EVEN, 2'h0}, {IDX_CONV4_ODD, 2'h0}, {IDX_CONV3_EVEN, 2'h0},
    {IDX_CONV3_ODD, 2'h0}, {IDX_CONV2_EVEN, 2'h0}};

  // correction register fields
  localparam int GAIN_MSB   = 15;
  localparam int GAIN_LSB   = 11;
  localparam int OFFSET_MSB = 9;
  localparam int OFFSET_LSB = 0;
  // enables register fields
  localparam int GAIN_EN_BIT   = 12;
  localparam int OFFSET_EN_BIT = 8;
  localparam int RES_LSB       = 0;
  localparam int RES_MSB       = 1;
  // status register fields
  localparam int LAST_MSB      = 13;
  localparam int CLIP_SEEN_BIT = 16;

  localparam logic [REG_W-1:0] CORR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    RES_14 = 2'b00,
    RES_12 = 2'b01,
    RES_10 = 2'b10
  } res_t;

  typedef enum logic [1:0] {
    CONV2 = 2'b00,
    CONV3 = 2'b01,
    CONV4 = 2'b10
  } conv_t;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : gain_offset_pkg

// ---- rtl/corr_datapath.sv ----
/*
  Combinational correction of one sample: sign extension at the active
  resolution, offset subtraction, gain in 0.2 dB steps, saturation.
  Assumes the caller registers the result and supplies the register fields.
*/
`timescale 1ns/10ps
`default_nettype none

module corr_datapath
  import gain_offset_pkg::*;
(
  // sample and correction fields in
  input  wire logic [gain_offset_pkg::SAMPLE_W-1:0] sample,
  input  wire logic [gain_offset_pkg::OFFSET_W-1:0] offset,
  input  wire logic [gain_offset_pkg::GAIN_W-1:0]   gain,
  // controls
  input  wire logic                                 gain_en,
  input  wire logic                                 offset_en,
  input  wire logic [1:0]                           res,
  // result
  output logic      [gain_offset_pkg::SAMPLE_W-1:0] result,
  output logic                                      clip
);

  // 10^(n/100) in unsigned q.12
  function automatic logic [MULT_W-1:0] gain_mult(input logic [GAIN_W-1:0] n);
    logic [MULT_W-1:0] m;
    case (n)
      5'h00: m = 15'h1000;
      5'h01: m = 15'h105F;
      5'h02: m = 15'h10C1;
      5'h03: m = 15'h1125;
      5'h04: m = 15'h118B;
      5'h05: m = 15'h11F4;
      5'h06: m = 15'h125F;
      5'h07: m = 15'h12CC;
      5'h08: m = 15'h133C;
      5'h09: m = 15'h13AF;
      5'h0A: m = 15'h1425;
      5'h0B: m = 15'h149D;
      5'h0C: m = 15'h1518;
      5'h0D: m = 15'h1595;
      5'h0E: m = 15'h1616;
      5'h0F: m = 15'h169A;
      5'h10: m = 15'h1720;
      5'h11: m = 15'h17AA;
      5'h12: m = 15'h1838;
      5'h13: m = 15'h18C8;
      5'h14: m = 15'h195C;
      5'h15: m = 15'h19F3;
      5'h16: m = 15'h1A8E;
      5'h17: m = 15'h1B2C;
      5'h18: m = 15'h1BCE;
      5'h19: m = 15'h1C74;
      5'h1A: m = 15'h1D1D;
      5'h1B: m = 15'h1DCB;
      5'h1C: m = 15'h1E7D;
      5'h1D: m = 15'h1F32;
      5'h1E: m = 15'h1FED;
      default: m = 15'h20AB;
    endcase
    return m;
  endfunction : gain_mult

  logic        [3:0]          shift;
  logic signed [SAMPLE_W-1:0] s_ext;
  logic signed [15:0]         off_ext;
  logic signed [15:0]         diff;
  logic signed [15:0]         mult;
  logic signed [31:0]         scaled;
  logic signed [31:0]         max_v;
  logic signed [31:0]         min_v;

  always_comb begin
    case (res)
      RES_12:  shift = 4'h2;
      RES_10:  shift = 4'h4;
      default: shift = 4'h0;
    endcase
    s_ext   = $signed(sample << shift) >>> shift;
    // offset lsb is one 14-bit lsb, so coarser samples see it shifted down
    off_ext = offset_en ? 16'($signed(offset) >>> shift) : 16'sh0000; // [RULE3] [RULE4] [RULE5]
    diff    = 16'(s_ext) - off_ext; // [RULE3]
    mult    = gain_en ? $signed({1'b0, gain_mult(gain)}) : 16'sh1000; // [RULE1] [RULE2]
    scaled  = (32'(diff) * 32'(mult)) >>> GAIN_FRAC;
    max_v   = 32'sh0000_1FFF >>> shift;
    min_v   = -32'sh0000_2000 >>> shift;
    clip    = (scaled > max_v) || (scaled < min_v);
    if (scaled > max_v) begin
      result = max_v[SAMPLE_W-1:0];
    end else if (scaled < min_v) begin
      result = min_v[SAMPLE_W-1:0];
    end else begin
      result = scaled[SAMPLE_W-1:0];
    end
  end

endmodule : corr_datapath

`default_nettype wire

// ---- rtl/gain_offset_corr.sv ----
/*
  Per-stream gain and offset correction stage with its AXI4-Lite registers.
  Assumes samples arrive on aclk, right-justified at the active resolution,
  tagged with their converter and parity; one cycle from sample to result.
*/
// Our own choice: the AXI4-Lite interface to the registers.
//
// Overview of operation
// [RULE1] gain is field value times 0.2 dB
// [RULE2] gain only acts while global gain enabled
// [RULE3] offset subtracted while global offset enabled
// [RULE4] offset field is signed two's complement
// [RULE5] offset unit is one 14-bit lsb
// [RULE6] odd and even samples use separate corrections
// [RULE7] five correction registers at indices 10h to 14h
// [RULE8] correction fields read, write, reset to zero
// [RULE9] software writes bit 10 zero; unused
//
`timescale 1ns/10ps
`default_nettype none

module gain_offset_corr
  import gain_offset_pkg::*;
(
  // clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // axi4-lite write address
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [gain_offset_pkg::ADDR_W-1:0]   s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [gain_offset_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [gain_offset_pkg::STRB_W-1:0]   s_axi_wstrb,
  // axi4-lite write response
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic      [1:0]                           s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [gain_offset_pkg::ADDR_W-1:0]   s_axi_araddr,
  // axi4-lite read data
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic      [gain_offset_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]                           s_axi_rresp,
  // sample stream in
  input  wire logic                                 in_valid,
  input  wire logic [gain_offset_pkg::SAMPLE_W-1:0] in_sample,
  input  wire logic [1:0]                           in_conv,
  input  wire logic                                 in_odd,
  // corrected stream out
  output logic                                      out_valid,
  output logic      [gain_offset_pkg::SAMPLE_W-1:0] out_sample,
  output logic                                      out_clip
);

  import gain_offset_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [NUM_CORR-1:0][REG_W-1:0] corr;
    logic                           global_gain_enable;
    logic                           global_offset_enable;
    logic [1:0]                     res;
    logic                           aw_got;
    logic                           w_got;
    logic [ADDR_W-1:0]              awaddr;
    logic [DATA_W-1:0]              wdata;
    logic [STRB_W-1:0]              wstrb;
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [DATA_W-1:0]              rdata;
    logic [1:0]                     rresp;
    logic                           out_valid;
    logic [SAMPLE_W-1:0]            out_sample;
    logic                           out_clip;
    logic [SAMPLE_W-1:0]            last_sample;
    logic                           clip_seen;
  } corr_state_t;

  corr_state_t state_ff;
  corr_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0]  old,
                                               input logic [DATA_W-1:0] data,
                                               input logic [STRB_W-1:0] strb);
    logic [REG_W-1:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge16

  function automatic logic [REG_W-1:0] enables_word(input corr_state_t s);
    logic [REG_W-1:0] w;
    w                  = '0;
    w[GAIN_EN_BIT]     = s.global_gain_enable;
    w[OFFSET_EN_BIT]   = s.global_offset_enable;
    w[RES_MSB:RES_LSB] = s.res;
    return w;
  endfunction : enables_word

  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'h0};
  endfunction : word_addr

  ////////////////////////////////////////////////////////////////////////////////
  // stream selection and correction

  logic                       sel_hit;
  logic [2:0]                 sel_idx;
  logic [REG_W-1:0]           sel_reg;
  logic [SAMPLE_W-1:0]        dp_result;
  logic                       dp_clip;

  always_comb begin
    sel_hit = 1'b1;
    sel_idx = 3'h0;
    // each converter parity except conv2 odd owns its own register; conv2 odd passes uncorrected
    case (in_conv) // [RULE6]
      CONV2:   begin
        sel_idx = 3'h0;
        sel_hit = !in_odd;
      end
      CONV3:   sel_idx = in_odd ? 3'h1 : 3'h2;
      CONV4:   sel_idx = in_odd ? 3'h3 : 3'h4;
      default: sel_hit = 1'b0;
    endcase
    sel_reg = sel_hit ? state_ff.corr[sel_idx] : CORR_RESET;
  end

  // bit 10 of the correction word is not routed to the datapath
  corr_datapath u_datapath ( // [RULE9]
    .sample    (in_sample),
    .offset    (sel_reg[OFFSET_MSB:OFFSET_LSB]),
    .gain      (sel_reg[GAIN_MSB:GAIN_LSB]),
    .gain_en   (state_ff.global_gain_enable && sel_hit),
    .offset_en (state_ff.global_offset_enable && sel_hit),
    .res       (state_ff.res),
    .result    (dp_result),
    .clip      (dp_clip)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [ADDR_W-1:0] wr_word;
  logic [ADDR_W-1:0] rd_word;
  logic              wr_hit;
  logic              rd_hit;
  logic [REG_W-1:0]  en_new;
  logic [DATA_W-1:0] rd_data;

  always_comb begin
    nxt_state = state_ff;
    wr_word   = word_addr(state_ff.awaddr);
    rd_word   = word_addr(s_axi_araddr);
    wr_hit    = 1'b0;
    rd_hit    = 1'b0;
    en_new    = enables_word(state_ff);
    rd_data   = '0;

    // address and data may be taken in either order
    if (s_axi_awvalid && state_ff.awready) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end

    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      for (int i = 0; i < NUM_CORR; i++) begin
        if (wr_word == CORR_ADDR[i]) begin
          nxt_state.corr[i] = merge16(state_ff.corr[i], state_ff.wdata, // [RULE7] [RULE8]
                                      state_ff.wstrb);
          wr_hit = 1'b1;
        end
      end
      if (wr_word == ADDR_ENABLES) begin
        en_new                         = merge16(en_new, state_ff.wdata, state_ff.wstrb);
        nxt_state.global_gain_enable   = en_new[GAIN_EN_BIT];
        nxt_state.global_offset_enable = en_new[OFFSET_EN_BIT];
        nxt_state.res                  = en_new[RES_MSB:RES_LSB];
        wr_hit                         = 1'b1;
      end
      if (wr_word == ADDR_STATUS) begin
        // write one to clear the sticky clip flag
        if (state_ff.wstrb[2] && state_ff.wdata[CLIP_SEEN_BIT]) begin
          nxt_state.clip_seen = 1'b0;
        end
        wr_hit = 1'b1;
      end
      nxt_state.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready  = !nxt_state.w_got && !nxt_state.bvalid;

    // read port
    for (int i = 0; i < NUM_CORR; i++) begin
      if (rd_word == CORR_ADDR[i]) begin
        rd_data = {{(DATA_W-REG_W){1'b0}}, state_ff.corr[i]}; // [RULE7] [RULE8]
        rd_hit  = 1'b1;
      end
    end
    if (rd_word == ADDR_ENABLES) begin
      rd_data = {{(DATA_W-REG_W){1'b0}}, enables_word(state_ff)};
      rd_hit  = 1'b1;
    end
    if (rd_word == ADDR_STATUS) begin
      rd_data                   = '0;
      rd_data[LAST_MSB:0]       = state_ff.last_sample;
      rd_data[CLIP_SEEN_BIT]    = state_ff.clip_seen;
      rd_hit                    = 1'b1;
    end
    if (s_axi_arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = rd_hit ? rd_data : '0;
      nxt_state.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    nxt_state.arready = !nxt_state.rvalid;

    // sample path; a clip in the same cycle as a clear keeps the flag set
    nxt_state.out_valid = in_valid;
    if (in_valid) begin
      nxt_state.out_sample  = dp_result; // [RULE1] [RULE3]
      nxt_state.out_clip    = dp_clip;
      nxt_state.last_sample = dp_result;
      if (dp_clip) begin
        nxt_state.clip_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0; // [RULE8]
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready  = state_ff.wready;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rdata   = state_ff.rdata;
  assign s_axi_rresp   = state_ff.rresp;
  assign out_valid     = state_ff.out_valid;
  assign out_sample    = state_ff.out_sample;
  assign out_clip      = state_ff.out_clip;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic plain_path;
  assign plain_path = in_valid && state_ff.res == RES_14 && in_sample == 14'h0100;

  gain_max_a: assert property ( // [RULE1]
    plain_path && in_conv == CONV3 && !in_odd && state_ff.global_gain_enable
    && !state_ff.global_offset_enable && state_ff.corr[2][GAIN_MSB:GAIN_LSB] == 5'h1F
    |=> out_sample == 14'h020A)
    else $error("gain step 31 not applied");

  gain_off_a: assert property ( // [RULE2]
    plain_path && !state_ff.global_gain_enable && !state_ff.global_offset_enable
    |=> out_valid && out_sample == 14'h0100 && !out_clip)
    else $error("sample altered while corrections disabled");

  offset_sub_a: assert property ( // [RULE3]
    plain_path && in_conv == CONV4 && !in_odd && !state_ff.global_gain_enable
    && state_ff.global_offset_enable && state_ff.corr[4][OFFSET_MSB:OFFSET_LSB] == 10'h010
    |=> out_sample == 14'h00F0)
    else $error("offset not subtracted");

  offset_sign_a: assert property ( // [RULE4]
    plain_path && in_conv == CONV4 && in_odd && !state_ff.global_gain_enable
    && state_ff.global_offset_enable && state_ff.corr[3][OFFSET_MSB:OFFSET_LSB] == 10'h3FF
    |=> out_sample == 14'h0101)
    else $error("negative offset not added back");

  offset_scale_a: assert property ( // [RULE5]
    in_valid && in_sample == 14'h0100 && state_ff.res == RES_12 && in_conv == CONV3
    && in_odd && !state_ff.global_gain_enable && state_ff.global_offset_enable
    && state_ff.corr[1][OFFSET_MSB:OFFSET_LSB] == 10'h004
    |=> out_sample == 14'h00FF)
    else $error("offset not scaled for 12-bit samples");

  parity_sel_a: assert property ( // [RULE6]
    plain_path && in_conv == CONV2 && in_odd
    |=> out_sample == 14'h0100)
    else $error("uncorrected stream was altered");

  read_map_a: assert property ( // [RULE7]
    s_axi_arvalid && s_axi_arready && word_addr(s_axi_araddr) == CORR_ADDR[2]
    |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
        && s_axi_rdata == {16'h0000, $past(state_ff.corr[2])})
    else $error("correction register read mismatch");

  reset_zero_a: assert property ( // [RULE8]
    $rose(aresetn) |-> state_ff.corr == '0 && !state_ff.global_gain_enable)
    else $error("correction registers not cleared by reset");

  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule : gain_offset_corr

`default_nettype wire

// ---- bench/gain_offset_corr_test.sv ----
/*
  Self-checking bench for the gain and offset correction stage.
  Assumes the package and the design are compiled first; the bench drives
  the register bus and the sample stream itself.
*/
`timescale 1ns/10ps
`default_nettype none

module gain_offset_corr_test;
  import gain_offset_pkg::*;

  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic                s_axi_awvalid = 1'b0, s_axi_awready;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0;
  logic                s_axi_wvalid = 1'b0, s_axi_wready;
  logic [DATA_W-1:0]   s_axi_wdata = '0;
  logic [STRB_W-1:0]   s_axi_wstrb = '0;
  logic                s_axi_bvalid, s_axi_bready = 1'b0;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic                s_axi_arvalid = 1'b0, s_axi_arready;
  logic [ADDR_W-1:0]   s_axi_araddr = '0;
  logic                s_axi_rvalid, s_axi_rready = 1'b0;
  logic [DATA_W-1:0]   s_axi_rdata;
  logic                in_valid = 1'b0, in_odd = 1'b0, out_valid, out_clip;
  logic [1:0]          in_conv = 2'b11;
  logic [SAMPLE_W-1:0] in_sample = '0, out_sample;
  int                  n_errors = 0, check_count = 0, sh = 0;
  logic                ge = 1'b0, oe = 1'b0;

  // stream order matches CORR_ADDR entries
  localparam logic [1:0] S_CONV [NUM_CORR] = '{CONV2, CONV3, CONV3, CONV4, CONV4};
  localparam logic       S_ODD  [NUM_CORR] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [15:0] OFFS  [NUM_CORR] = '{16'h01FF, 16'h0007, 16'h0200, 16'h03FF, 16'h0010};

  always #5 aclk = ~aclk;

  gain_offset_corr i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .in_valid(in_valid),
    .in_sample(in_sample), .in_conv(in_conv), .in_odd(in_odd), .out_valid(out_valid),
    .out_sample(out_sample), .out_clip(out_clip));

  //////////////////////////////////////////////////////////////////////////////

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [1:0] er, input int bwait = 0);
    int i;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= (bwait == 0);
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      // hold the response off for bwait cycles
      if (s_axi_bvalid === 1'b1 && bwait > 0) begin
        bwait--;
      end else if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    if (i == 20) begin
      check(1'b0, "write timeout");
      test_done();
    end
    check(s_axi_bresp === er, "write response");
    // let an edge pass before the next request
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int i;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 20) begin
      check(1'b0, "read timeout");
      test_done();
    end
    check(s_axi_rdata === ed && s_axi_rresp === er, "read data or response");
    @(posedge aclk);
  endtask : axi_read

  task automatic set_en(input logic g, input logic o, input logic [1:0] r);
    axi_write(ADDR_ENABLES, {19'h0, g, 3'h0, o, 6'h0, r}, RESP_OKAY);
    ge = g;
    oe = o;
    sh = (r == 2'b01) ? 2 : (r == 2'b10) ? 4 : 0;
  endtask : set_en

  // expected {clip, sample}: offset, then gain, then saturation
  function automatic logic [14:0] model(input int s, input logic [15:0] r);
    int d, m, lim;
    d = s;
    if (oe) d = d - ($signed(r[9:0]) >>> sh);
    if (ge) begin
      m = $rtoi(4096.0 * 10.0 ** (r[15:11] / 100.0) + 0.5);
      d = (d * m) >>> 12;
    end
    lim = 1 << (13 - sh);
    if (d > lim - 1) return {1'b1, 14'(lim - 1)};
    if (d < -lim) return {1'b1, 14'(-lim)};
    return {1'b0, d[13:0]};
  endfunction : model

  task automatic send(input int s, input logic [1:0] c, input logic odd, input logic [15:0] r);
    logic [14:0] e;
    e = model(s, r);
    in_valid <= 1'b1;
    in_sample <= s[13:0];
    in_conv <= c;
    in_odd <= odd;
    @(posedge aclk);
    in_valid <= 1'b0;
    @(posedge aclk);
    check(out_valid === 1'b1 && out_sample === e[13:0] && out_clip === e[14], "sample result");
    @(posedge aclk);
    check(out_valid === 1'b0, "out_valid longer than one cycle");
  endtask : send

  //////////////////////////////////////////////////////////////////////////////

  task automatic t_regs();
    int i;
    for (i = 0; i < NUM_CORR; i++) axi_read(CORR_ADDR[i], 32'h0, RESP_OKAY);
    for (i = 0; i < NUM_CORR; i++) axi_write(CORR_ADDR[i], 32'hFBFF - i, RESP_OKAY);
    for (i = 0; i < NUM_CORR; i++) axi_read(CORR_ADDR[i], 32'hFBFF - i, RESP_OKAY);
    axi_write(8'h60, 32'h1234, RESP_SLVERR);
    axi_read(8'h60, 32'h0, RESP_SLVERR);
  endtask : t_regs

  task automatic t_offset();
    int i;
    set_en(1'b0, 1'b1, 2'b00);
    for (i = 0; i < NUM_CORR; i++) axi_write(CORR_ADDR[i], {16'h0, OFFS[i]}, RESP_OKAY);
    for (i = 0; i < NUM_CORR; i++) send(256, S_CONV[i], S_ODD[i], OFFS[i]);
    send(256, CONV2, 1'b1, 16'h0);
    send(256, 2'b11, 1'b0, 16'h0);
    set_en(1'b0, 1'b0, 2'b00);
    for (i = 0; i < NUM_CORR; i++) send(256, S_CONV[i], S_ODD[i], OFFS[i]);
  endtask : t_offset

  task automatic t_gain();
    int i;
    logic [15:0] r;
    logic [4:0] n [4] = '{5'd0, 5'd1, 5'd5, 5'd31};
    set_en(1'b1, 1'b0, 2'b00);
    for (i = 0; i < 4; i++) begin
      r = {n[i], 11'h010};
      axi_write(CORR_ADDR[4], {16'h0, r}, RESP_OKAY);
      send(-1000, CONV4, 1'b0, r);
      send(6000, CONV4, 1'b0, r);
    end
    axi_write(CORR_ADDR[2], 32'hF800, RESP_OKAY);
    send(256, CONV3, 1'b0, 16'hF800);
    send(1000, CONV4, 1'b1, OFFS[3]);
    set_en(1'b0, 1'b0, 2'b00);
    send(6000, CONV4, 1'b0, r);
  endtask : t_gain

  task automatic t_res();
    logic [15:0] r;
    r = {5'd10, 1'b0, 10'h008};
    axi_write(CORR_ADDR[1], 32'h0004, RESP_OKAY);
    set_en(1'b0, 1'b1, 2'b01);
    send(256, CONV3, 1'b1, 16'h0004);
    axi_write(CORR_ADDR[1], {16'h0, r}, RESP_OKAY);
    set_en(1'b1, 1'b1, 2'b01);
    send(500, CONV3, 1'b1, r);
    send(2047, CONV3, 1'b1, r);
    set_en(1'b1, 1'b1, 2'b10);
    send(200, CONV3, 1'b1, r);
    axi_read(ADDR_ENABLES, 32'h0000_1102, RESP_OKAY);
    // sticky clip held since the 6000 sample at gain step 31 in t_gain, last result 251
    axi_read(ADDR_STATUS, 32'h0001_00FB, RESP_OKAY);
    axi_write(ADDR_STATUS, 32'h0001_0000, RESP_OKAY, 3);
    axi_read(ADDR_STATUS, 32'h0000_00FB, RESP_OKAY);
  endtask : t_res

  // reset in mid-run must clear registers that hold non-zero values
  task automatic t_reset();
    int i;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ge = 1'b0;
    oe = 1'b0;
    sh = 0;
    for (i = 0; i < NUM_CORR; i++) axi_read(CORR_ADDR[i], 32'h0, RESP_OKAY);
    axi_read(ADDR_ENABLES, 32'h0, RESP_OKAY);
    send(256, CONV3, 1'b1, 16'h0);
  endtask : t_reset

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_offset();
    t_gain();
    t_res();
    t_reset();
    test_done();
  end

endmodule : gain_offset_corr_test

`default_nettype wire
